// file: logic/clock_synth.sv
// fractional-n clock synthesis core with four divided outputs and lock tracking
`timescale 1ns/1ns
module clock_synth #(
  parameter int LOCK_TOL_P = 1
) (
  input  wire logic                                        clk,
  input  wire logic                                        arst_n,
  input  wire logic                                        reference_clock_in_pin,
  input  wire logic                                        reference_clock_in_route,
  input  wire logic                                        ref_from_route,
  input  wire logic                                        feedback_clock_in_pin,
  input  wire logic                                        feedback_clock_in_route,
  input  wire logic                                        fb_from_pin,
  input  wire logic [synth_pkg::INT_W-1:0]                 fb_mult_int,
  input  wire logic [synth_pkg::FRAC_W-1:0]                fb_mult_frac,
  input  wire logic [synth_pkg::N_OUT-1:0][synth_pkg::DIV_W-1:0]   out_divide,
  input  wire logic [synth_pkg::N_OUT-1:1]                 cascade_from_prev,
  input  wire logic [synth_pkg::N_OUT-1:1][synth_pkg::PHASE_W-1:0] phase_steps,
  input  wire logic [synth_pkg::N_OUT-1:1]                 phase_advance,
  output logic                                             primary_clock_out,
  output logic                                             secondary_clock_out_one,
  output logic                                             secondary_clock_out_two,
  output logic                                             secondary_clock_out_three,
  output logic [synth_pkg::N_OUT-1:0]                      route_clock_out,
  output logic                                             lock
);
  import synth_pkg::*;

  localparam int ACC_W = PERIOD_W + FRAC_W + 1;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (INT_W > PERIOD_W) begin : g_chk_int
    $error("multiplier wider than reference period counter");
  end
  if (DIV_MAX >= (1 << DIV_W)) begin : g_chk_div
    $error("divider width cannot hold largest ratio");
  end
  if (LOCK_TOL_P < 0 || LOCK_TOL_P > 255) begin : g_chk_tol
    $error("lock tolerance out of range");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                  ref_sel;
  logic                  fb_sel;
  logic                  ref_prev_ff;
  logic                  fb_prev_ff;
  logic                  ref_rise;
  logic                  fb_rise;
  logic [PERIOD_W-1:0]   period_cnt_ff;
  logic [PERIOD_W-1:0]   period_ff;
  logic [INT_W:0]        fb_cnt_ff;
  logic [GOOD_W-1:0]     good_ff;
  lock_state_t           state_ff;
  lock_state_t           nxt_state;
  logic [GOOD_W-1:0]     nxt_good;
  logic                  fb_match;
  logic [INT_W:0]        fb_diff;
  logic                  lock_ff;
  logic                  sync_ff;
  logic [ACC_W-1:0]      acc_ff;
  logic [ACC_W-1:0]      acc_sum;
  logic [ACC_W-1:0]      acc_thr;
  logic [ACC_W-1:0]      acc_step;
  logic                  vco_tick_ff;
  logic [N_OUT-1:0]      clk_net_ff;
  logic [N_OUT-1:0]      route_ff;
  logic [N_OUT-1:0]      div_level;
  logic [N_OUT-1:0]      div_tick;

  // ---------------------------------------------------------------
  // input source selection
  // ---------------------------------------------------------------
  assign ref_sel  = ref_from_route ? reference_clock_in_route
                                   : reference_clock_in_pin;
  assign fb_sel   = fb_from_pin ? feedback_clock_in_pin
                                : feedback_clock_in_route;
  assign ref_rise = ref_sel & ~ref_prev_ff;
  assign fb_rise  = fb_sel & ~fb_prev_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_prev_ff <= 1'b0;
      fb_prev_ff  <= 1'b0;
    end else begin
      ref_prev_ff <= ref_sel;
      fb_prev_ff  <= fb_sel;
    end
  end

  // ---------------------------------------------------------------
  // reference period and feedback edge counts
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      period_cnt_ff <= PERIOD_RST;
      period_ff     <= PERIOD_RST;
    end else if (ref_rise) begin
      period_cnt_ff <= PERIOD_RST + 16'h0001;
      period_ff     <= period_cnt_ff;
    end else if (period_cnt_ff != PERIOD_SAT) begin
      period_cnt_ff <= period_cnt_ff + 16'h0001;
    end
  end

  // an edge that lands with the reference edge opens the next window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_cnt_ff <= '0;
    end else if (ref_rise) begin
      fb_cnt_ff <= {{INT_W{1'b0}}, fb_rise};
    end else if (fb_rise && fb_cnt_ff != {(INT_W+1){1'b1}}) begin
      fb_cnt_ff <= fb_cnt_ff + {{INT_W{1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // lock tracking
  // ---------------------------------------------------------------
  always_comb begin
    if (fb_cnt_ff > {1'b0, fb_mult_int}) begin
      fb_diff = fb_cnt_ff - {1'b0, fb_mult_int};
    end else begin
      fb_diff = {1'b0, fb_mult_int} - fb_cnt_ff;
    end
    fb_match = (fb_diff <= (INT_W+1)'(LOCK_TOL_P)) && (fb_mult_int != '0);
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_good  = good_ff;
    unique case (state_ff)
      ST_MEASURE: begin
        nxt_good = '0;
        if (ref_rise) begin
          nxt_state = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (period_cnt_ff == PERIOD_SAT) begin
          nxt_state = ST_MEASURE;
        end else if (ref_rise) begin
          if (!fb_match) begin
            nxt_good = '0;
          end else if (good_ff == LOCK_GOOD - 4'h1) begin
            nxt_state = ST_LOCKED;
          end else begin
            nxt_good = good_ff + 4'h1;
          end
        end
      end
      ST_LOCKED: begin
        nxt_good = '0;
        if (period_cnt_ff == PERIOD_SAT) begin
          nxt_state = ST_MEASURE;
        end else if (ref_rise && !fb_match) begin
          nxt_state = ST_ACQUIRE;
        end
      end
      default: begin
        nxt_state = ST_MEASURE;
        nxt_good  = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_MEASURE;
      good_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      good_ff  <= nxt_good;
    end
  end

  // dividers are held aligned until lock so phases start from a known point
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_ff <= 1'b0;
      sync_ff <= 1'b1;
    end else begin
      lock_ff <= (nxt_state == ST_LOCKED);
      sync_ff <= (nxt_state != ST_LOCKED);
    end
  end

  // ---------------------------------------------------------------
  // fractional-n phase accumulator
  // ---------------------------------------------------------------
  // one tick per clk at most; a multiplier beyond that saturates
  assign acc_thr  = {1'b0, period_ff, {FRAC_W{1'b0}}};
  assign acc_step = ACC_W'({fb_mult_int, fb_mult_frac});
  assign acc_sum  = acc_ff + acc_step;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff      <= '0;
      vco_tick_ff <= 1'b0;
    end else if (state_ff == ST_MEASURE || period_ff == PERIOD_RST) begin
      acc_ff      <= '0;
      vco_tick_ff <= 1'b0;
    end else if (acc_sum >= acc_thr) begin
      vco_tick_ff <= 1'b1;
      if (acc_step < acc_thr) begin
        acc_ff <= acc_sum - acc_thr;
      end
    end else begin
      acc_ff      <= acc_sum;
      vco_tick_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output dividers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N_OUT; i++) begin : g_div
    out_div_if div_bus ();

    if (i == 0) begin : g_prim
      assign div_bus.tick_in = vco_tick_ff;
      assign div_bus.advance = 1'b0;
      assign div_bus.phase   = '0;
    end else begin : g_sec
      assign div_bus.tick_in = cascade_from_prev[i] ? div_tick[i-1]
                                                    : vco_tick_ff;
      assign div_bus.advance = phase_advance[i];
      assign div_bus.phase   = phase_steps[i];
    end
    assign div_bus.sync   = sync_ff;
    assign div_bus.divide = out_divide[i];
    assign div_level[i]   = div_bus.level;
    assign div_tick[i]    = div_bus.tick_out;

    out_divider u_div (
      .clk     (clk),
      .arst_n  (arst_n),
      .port_if (div_bus.div)
    );
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // separate copies so the network and routing loads stay independent
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_net_ff <= '0;
      route_ff   <= '0;
    end else begin
      clk_net_ff <= div_level;
      route_ff   <= div_level;
    end
  end

  assign primary_clock_out         = clk_net_ff[0];
  assign secondary_clock_out_one   = clk_net_ff[1];
  assign secondary_clock_out_two   = clk_net_ff[2];
  assign secondary_clock_out_three = clk_net_ff[3];
  assign route_clock_out           = route_ff;
  assign lock                      = lock_ff;
endmodule

// file: logic/out_div_if.sv
// signals between the synthesis core and one output divider
`timescale 1ns/1ns
interface out_div_if;
  import synth_pkg::*;

  logic               tick_in;
  logic               sync;
  logic               advance;
  logic [DIV_W-1:0]   divide;
  logic [PHASE_W-1:0] phase;
  logic               tick_out;
  logic               level;

  modport core (
    output tick_in,
    output sync,
    output advance,
    output divide,
    output phase,
    input  tick_out,
    input  level
  );

  modport div (
    input  tick_in,
    input  sync,
    input  advance,
    input  divide,
    input  phase,
    output tick_out,
    output level
  );
endinterface

// file: logic/out_divider.sv
// one output divider with phase preload
`timescale 1ns/1ns
module out_divider (
  input  wire logic clk,
  input  wire logic arst_n,
  out_div_if.div    port_if
);
  import synth_pkg::*;

  logic [DIV_W-1:0]   cnt_ff;
  logic               tick_ff;
  logic               level_ff;
  logic [DIV_W-1:0]   div_eff;
  logic [DIV_W-1:0]   ph_eff;
  logic [DIV_W-1:0]   nxt_preload;
  logic               skip_ff;
  logic               nxt_skip;

  // ---------------------------------------------------------------
  // ratio and phase decode
  // ---------------------------------------------------------------
  always_comb begin
    div_eff = clamp_div(port_if.divide);
    ph_eff  = {1'b0, port_if.phase};
    if (ph_eff >= div_eff) begin
      ph_eff = div_eff - DIV_MIN;
    end
    // a preload of k wraps k ticks early; delay uses the complement
    // a delayed output skips its first toggle, else it runs half a period late
    if (port_if.advance || ph_eff == '0) begin
      nxt_preload = ph_eff;
      nxt_skip    = 1'b0;
    end else begin
      nxt_preload = div_eff - ph_eff;
      nxt_skip    = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff   <= '0;
      tick_ff  <= 1'b0;
      level_ff <= 1'b0;
      skip_ff  <= 1'b0;
    end else if (port_if.sync) begin
      cnt_ff   <= nxt_preload;
      tick_ff  <= 1'b0;
      level_ff <= 1'b0;
      skip_ff  <= nxt_skip;
    end else begin
      tick_ff <= 1'b0;
      if (port_if.tick_in) begin
        if (cnt_ff >= div_eff - DIV_MIN) begin
          cnt_ff   <= '0;
          tick_ff  <= ~skip_ff;
          level_ff <= level_ff ^ ~skip_ff;
          skip_ff  <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff + DIV_MIN;
        end
      end
    end
  end

  assign port_if.tick_out = tick_ff;
  assign port_if.level    = level_ff;
endmodule

// file: logic/synth_pkg.sv
// constants, types and helpers shared by the clock synthesis block
// Notes on behaviour
// - reference input from pin or routing, selectable
// - feedback input from routing or pin, selectable
// - feedback multiplier raises reference to higher frequency
// - fractional multiplier with 16-bit fraction resolution
// - each output has its own divider
// - every divider accepts ratios 1 through 128
// - dividers may chain, ratios multiply
// - all four outputs reach clock network and routing
// - lock rises when locked, drops on loss
// - secondaries shift phase ahead or behind primary
package synth_pkg;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int N_OUT     = 4;
  localparam int FRAC_W    = 16;
  localparam int INT_W     = 8;
  localparam int DIV_W     = 8;
  localparam int PHASE_W   = 7;
  localparam int PERIOD_W  = 16;
  localparam int GOOD_W    = 4;

  localparam logic [DIV_W-1:0]    DIV_MIN      = 8'h01;
  localparam logic [DIV_W-1:0]    DIV_MAX      = 8'h80;
  localparam logic [GOOD_W-1:0]   LOCK_GOOD    = 4'h8;
  localparam logic [INT_W-1:0]    LOCK_TOL     = 8'h01;
  localparam logic [PERIOD_W-1:0] PERIOD_SAT   = 16'hFFFF;
  localparam logic [PERIOD_W-1:0] PERIOD_RST   = 16'h0000;

  // ---------------------------------------------------------------
  // lock tracking states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_MEASURE = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_LOCKED  = 2'b10
  } lock_state_t;

  // out-of-range ratios are pulled to the nearest legal one
  function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
    logic [DIV_W-1:0] r;
    r = d;
    if (d < DIV_MIN) begin
      r = DIV_MIN;
    end else if (d > DIV_MAX) begin
      r = DIV_MAX;
    end
    return r;
  endfunction

endpackage

// file: tb/clock_synth_checker.sv
// port assertions for the clock synthesis block
`timescale 1ns/1ns
module clock_synth_checker #(
  parameter int LOCK_TOL_P = 1
) (
  input wire logic                        clk,
  input wire logic                        arst_n,
  input wire logic                        reference_clock_in_pin,
  input wire logic                        reference_clock_in_route,
  input wire logic                        ref_from_route,
  input wire logic                        feedback_clock_in_pin,
  input wire logic                        feedback_clock_in_route,
  input wire logic                        fb_from_pin,
  input wire logic [synth_pkg::INT_W-1:0] fb_mult_int,
  input wire logic                        primary_clock_out,
  input wire logic                        secondary_clock_out_one,
  input wire logic                        secondary_clock_out_two,
  input wire logic                        secondary_clock_out_three,
  input wire logic [synth_pkg::N_OUT-1:0] route_clock_out,
  input wire logic                        lock
);
  import synth_pkg::*;
  logic        ref_s, fb_s, rq_ff, fq_ff, rise, bad, cause;
  logic [3:0]  net, nr_ff;
  logic [16:0] idle_ff;
  logic [7:0]  fbn_ff;
  logic [5:0]  rh_ff, ch_ff;
  assign net   = {secondary_clock_out_three, secondary_clock_out_two,
                  secondary_clock_out_one, primary_clock_out};
  assign ref_s = ref_from_route ? reference_clock_in_route : reference_clock_in_pin;
  assign fb_s  = fb_from_pin ? feedback_clock_in_pin : feedback_clock_in_route;
  assign rise  = ref_s & ~rq_ff;
  // window judged at each reference rise, edges counted on the selected source only
  assign bad   = rise && (fb_mult_int == 8'h00 || fbn_ff > fb_mult_int + LOCK_TOL_P
                 || fbn_ff + LOCK_TOL_P < fb_mult_int);
  assign cause = bad || idle_ff >= 17'h0_FFF0;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rq_ff   <= 1'b0;
      fq_ff   <= 1'b0;
      fbn_ff  <= 8'h00;
      idle_ff <= 17'h0_0000;
      nr_ff   <= 4'h0;
      rh_ff   <= 6'h00;
      ch_ff   <= 6'h00;
    end else begin
      rq_ff   <= ref_s;
      fq_ff   <= fb_s;
      fbn_ff  <= rise ? 8'h00 : fbn_ff + {7'h00, fb_s & ~fq_ff};
      idle_ff <= rise ? 17'h0_0000 : idle_ff + 17'h0_0001;
      nr_ff   <= nr_ff + {3'h0, rise && nr_ff != 4'hF};
      rh_ff   <= {rh_ff[4:0], rise};
      ch_ff   <= {ch_ff[4:0], cause};
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_route_mirror: assert property (route_clock_out == net)
    else $error("routing copies differ from network outputs");
  a_reset_quiet: assert property (!$past(arst_n) |-> !lock && net == 4'h0)
    else $error("outputs not quiet after reset");
  a_held_unlocked: assert property ((!lock)[*4] |-> net == 4'h0)
    else $error("output moves while unlocked");
  a_lock_after_rise: assert property ($rose(lock) |-> |rh_ff)
    else $error("lock rose away from a reference rise");
  a_lock_needs_windows: assert property ($rose(lock) |-> nr_ff >= 4'h9)
    else $error("lock rose before eight good windows");
  a_bad_window_drop: assert property (lock && bad |-> ##[1:6] !lock)
    else $error("lock kept after a bad window");
  a_fall_has_cause: assert property ($fell(lock) |-> |ch_ff)
    else $error("lock fell without a cause");
  a_idle_drop: assert property (idle_ff > 17'h1_0009 |-> !lock)
    else $error("lock kept with reference stopped");
  c_lock_rise: cover property ($rose(lock));
  c_lock_fall: cover property ($fell(lock));
  c_third_moves: cover property (lock && $changed(secondary_clock_out_three));
endmodule

// file: tb/clock_synth_tb.sv
// self-checking bench for the clock synthesis block
`timescale 1ns/1ns
module clock_synth_tb;
  import synth_pkg::*;
  logic                          clk = 1'b0;
  logic                          arst_n = 1'b0;
  logic                          run = 1'b0;
  logic                          junk = 1'b0;
  logic                          ref_from_route = 1'b0;
  logic                          fb_from_pin = 1'b0;
  logic [7:0]                    fbn = 8'h04;
  logic [INT_W-1:0]              fb_mult_int = 8'h04;
  logic [FRAC_W-1:0]             fb_mult_frac = 16'h0000;
  logic [N_OUT-1:0][DIV_W-1:0]   out_divide = 32'h0101_0101;
  logic [N_OUT-1:1]              cascade_from_prev = 3'h0;
  logic [N_OUT-1:1][PHASE_W-1:0] phase_steps = 21'h00_0000;
  logic [N_OUT-1:1]              phase_advance = 3'h0;
  logic                          ref_o, fb_o, p, s1, s2, s3, lock;
  logic [N_OUT-1:0]              rco;
  logic [15:0]                   edges, e;
  int                            n_mismatch = 0;
  int                            samples_checked = 0;
  int                            cycles = 0;
  int                            cnt [N_OUT];
  always #2 clk = ~clk;
  // the unselected source toggles every cycle, so a wrong pick breaks lock
  always @(negedge clk) junk <= ~junk;
  clock_synth i_dut (
    .clk, .arst_n, .ref_from_route, .fb_from_pin,
    .reference_clock_in_pin   (ref_from_route ? junk : ref_o),
    .reference_clock_in_route (ref_from_route ? ref_o : junk),
    .feedback_clock_in_pin    (fb_from_pin ? fb_o : junk),
    .feedback_clock_in_route  (fb_from_pin ? junk : fb_o),
    .fb_mult_int, .fb_mult_frac, .out_divide, .cascade_from_prev,
    .phase_steps, .phase_advance, .lock,
    .primary_clock_out (p), .secondary_clock_out_one (s1),
    .secondary_clock_out_two (s2), .secondary_clock_out_three (s3),
    .route_clock_out (rco)
  );
  synth_far_side i_far (.clk, .run, .fbn, .lock, .prim (p), .ref_o, .fb_o, .edges);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input int tol);
    samples_checked++;
    if ($isunknown(seen) || seen + tol < expv || seen > expv + tol) begin
      n_mismatch++;
      $display("FAIL %0t seen %0d expected %0d", $time, seen, expv);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_lock(input logic v);
    for (int i = 0; i < 3000 && lock !== v; i++)
      @(negedge clk);
    check({15'h0000, lock}, {15'h0000, v}, 0);
  endtask
  // toggles per output over w cycles; one vco tick is 8 cycles here
  task automatic count(input int w);
    logic [N_OUT-1:0] q;
    cyc(64);
    e = edges;
    q = rco;
    cnt = '{default: 0};
    repeat (w) begin
      @(negedge clk);
      for (int i = 0; i < N_OUT; i++)
        cnt[i] += int'(rco[i] ^ q[i]);
      q = rco;
    end
  endtask
  // cycles from a primary toggle to the next toggle of output i
  task automatic gap(input int i, input int expv);
    int   n;
    logic q, r;
    n = 0;
    q = p;
    while (p === q)
      @(negedge clk);
    r = rco[i];
    while (rco[i] === r && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'(expv), 1);
    check({15'h0000, rco[i]}, {15'h0000, p ^ phase_advance[i]}, 0);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_rates;
    out_divide = 32'h8003_0201;
    count(2048);
    check({12'h000, s3, s2, s1, p}, {12'h000, rco}, 0);
    check(edges - e, 16'd256, 2);
    check(16'(cnt[0]), 16'd256, 2);
    check(16'(cnt[1]), 16'd128, 2);
    check(16'(cnt[2]), 16'd85, 2);
    check(16'(cnt[3]), 16'd2, 1);
  endtask
  task automatic t_frac;
    out_divide = 32'h0001_0101;
    fb_mult_frac = 16'h8000;
    count(2048);
    check(16'(cnt[0]), 16'd288, 2);
    check(16'(cnt[3]), 16'd288, 2);
    fb_mult_frac = 16'h0000;
  endtask
  task automatic t_cascade;
    out_divide = 32'h0101_0202;
    cascade_from_prev = 3'b011;
    count(2048);
    check(16'(cnt[1]), 16'd64, 2);
    check(16'(cnt[2]), 16'd64, 2);
    check(16'(cnt[3]), 16'd256, 2);
    cascade_from_prev = 3'h0;
  endtask
  task automatic t_phase;
    out_divide = 32'h0404_0404;
    phase_steps = {7'h02, 7'h01, 7'h01};
    phase_advance = 3'b001;
    fbn = 8'h08;
    chk_lock(1'b0);
    cyc(8);
    check({12'h000, rco}, 16'h0000, 0);
    fbn = 8'h04;
    chk_lock(1'b1);
    cyc(64);
    gap(1, 24);
    gap(2, 8);
    gap(3, 16);
  endtask
  task automatic t_stop_and_select;
    run = 1'b0;
    cyc(60000);
    check({15'h0000, lock}, 16'h0001, 0);
    cyc(6000);
    check({15'h0000, lock}, 16'h0000, 0);
    ref_from_route = 1'b1;
    fb_from_pin = 1'b1;
    run = 1'b1;
    chk_lock(1'b1);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    cyc(4);
    check({11'h000, lock, rco}, 16'h0000, 0);
    arst_n = 1'b1;
    run = 1'b1;
    chk_lock(1'b1);
    t_rates();
    t_frac();
    t_cascade();
    t_phase();
    t_stop_and_select();
    wrap_up();
  end
endmodule
bind clock_synth clock_synth_checker #(.LOCK_TOL_P(LOCK_TOL_P)) i_chk (
  .clk, .arst_n, .reference_clock_in_pin, .reference_clock_in_route, .ref_from_route,
  .feedback_clock_in_pin, .feedback_clock_in_route, .fb_from_pin, .fb_mult_int,
  .primary_clock_out, .secondary_clock_out_one, .secondary_clock_out_two,
  .secondary_clock_out_three, .route_clock_out, .lock
);

// file: tb/synth_far_side.sv
// far side model: reference and feedback sources plus a lock-aware consumer
`timescale 1ns/1ns
module synth_far_side (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] fbn,
  input  wire logic       lock,
  input  wire logic       prim,
  output logic            ref_o = 1'b0,
  output logic            fb_o = 1'b0,
  output logic [15:0]     edges = 16'h0000
);
  localparam int PERIOD = 32;
  int   t = 0;
  logic pq = 1'b0;
  // feedback edges fall mid-period, never on the reference rise
  always @(negedge clk) begin
    t = run ? (t + 1) % PERIOD : 0;
    ref_o <= run && t < PERIOD / 2;
    fb_o <= run && ((2 * t * fbn / PERIOD) % 2 == 1);
  end
  // consumer state held clear while unlocked, so stale edges never count
  always @(posedge clk) begin
    pq <= prim;
    edges <= !lock ? 16'h0000 : edges + {15'h0000, prim ^ pq};
  end
endmodule
